// File: core/pmac_pkg.sv
// constants and types of the power-line modem auxiliary control block
// Operation
// - bit 20 picks 8 or 16 bit header
// - extended bit allows all 48 bits writable
// - bits 24-39 hold frame header, default 9B58h
// - bits 40-47 hold frame length, default 08h
// - band flag gated by carrier detect
// - flag shows band on receive, heat on transmit
// - time-out forces receive after 1 or 3 s
// - transmit stays disabled at least 125 ms
// - lockout allows only register access or reception
// - both selects low at reset arms lockout
// - time-out length chosen by bits 7 and 8
// - reset output held low through startup delay
// - watchdog expiry resets device and reset output
// - clock output divides by 2, 4, 8 or stops
// - clock change waits for end of cycle
// - freeze level loop after 3 stable periods
// - freeze enabled by bit 17 low with extension
// - header, length and freeze need extension on
// - overheat cuts driver, flag follows it unlatched
package pmac_pkg;

  localparam int CFG_W         = 48;
  localparam int CFG_LOW_W     = 24;
  localparam int TOUT_LSB      = 7;
  localparam int MCLK_LSB      = 15;
  localparam int FREEZE_BIT    = 17;
  localparam int HDR_REC_BIT   = 18;
  localparam int FRM_CNT_BIT   = 19;
  localparam int HDR_LEN_BIT   = 20;
  localparam int EXT_BIT       = 21;
  localparam int SENS_BIT      = 22;
  localparam int FILT_BIT      = 23;
  localparam int HDR_LSB       = 24;
  localparam int LEN_LSB       = 40;

  // header 9B58, length 08, bit 20 set but extension off so 8-bit header, freeze off, 25 MHz out, 1 s time-out
  localparam logic [47:0] CFG_RESET = 48'h089B58136280;

  localparam logic [1:0] TOUT_SHORT  = 2'h1;
  localparam logic [1:0] TOUT_LONG   = 2'h2;
  localparam logic [1:0] MCLK_OFF    = 2'h3;

  localparam int CLK_MHZ        = 200;
  localparam int TOUT_SHORT_MS  = 1000;
  localparam int TOUT_LONG_MS   = 3000;
  localparam int LOCK_MS        = 125;
  localparam int WDOG_MS        = 1500;
  localparam int RSO_MS         = 50;
  localparam int FREEZE_PERIODS = 3;

  localparam int TOUT_SHORT_CYC = TOUT_SHORT_MS * CLK_MHZ * 1000;
  localparam int TOUT_LONG_CYC  = TOUT_LONG_MS * CLK_MHZ * 1000;
  localparam int LOCK_CYC       = LOCK_MS * CLK_MHZ * 1000;
  localparam int WDOG_CYC       = WDOG_MS * CLK_MHZ * 1000;
  localparam int RSO_CYC        = RSO_MS * CLK_MHZ * 1000;

  typedef enum logic [1:0] {
    PMAC_RX   = 2'h0,
    PMAC_TX   = 2'h1,
    PMAC_LOCK = 2'h3,
    PMAC_WAIT = 2'h2
  } pmac_tx_state_t;

  typedef struct packed {
    logic        header_recog_en;
    logic        frame_count_en;
    logic        header_16bit;
    logic        sensitivity_high;
    logic        input_filter_en;
    logic [15:0] header_pattern;
    logic [7:0]  frame_length;
  } pmac_ext_t;

endpackage

// File: core/pmac_clkdiv.sv
// master clock output divider with glitch-free ratio change
`timescale 1ns/10ps
module pmac_clkdiv (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       ce,
  input  wire logic       soft_rst,
  input  wire logic [1:0] sel,
  output logic            mclk
);

  logic [1:0] act_sel;
  logic [1:0] cnt;
  logic [1:0] next_act_sel;
  logic [1:0] next_cnt;
  logic       next_mclk;
  logic [1:0] half;

  always_comb begin
    half         = 2'(({1'b0, 1'b1} << act_sel) - 2'h1);
    next_act_sel = act_sel;
    next_cnt     = cnt;
    next_mclk    = mclk;
    if (soft_rst) begin
      next_act_sel = sel;
      next_cnt     = 2'h0;
      next_mclk    = 1'b0;
    end else if (act_sel == pmac_pkg::MCLK_OFF) begin
      next_act_sel = sel;
      next_cnt     = 2'h0;
      next_mclk    = 1'b0;
    end else if (cnt == half) begin
      next_cnt  = 2'h0;
      next_mclk = ~mclk;
      // a new ratio is only taken when a full cycle has ended
      if (mclk) begin
        next_act_sel = sel;
      end
    end else begin
      next_cnt = 2'(cnt + 2'h1);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      act_sel <= pmac_pkg::CFG_RESET[pmac_pkg::MCLK_LSB +: 2];
      cnt     <= 2'h0;
      mclk    <= 1'b0;
    end else if (ce) begin
      act_sel <= next_act_sel;
      cnt     <= next_cnt;
      mclk    <= next_mclk;
    end
  end

endmodule

// File: core/pmac_top.sv
// auxiliary control of the power-line modem: config, time-out, watchdog, flags
`timescale 1ns/10ps
module pmac_top #(
  parameter int TOUT_SHORT_CYC = pmac_pkg::TOUT_SHORT_CYC,
  parameter int TOUT_LONG_CYC  = pmac_pkg::TOUT_LONG_CYC,
  parameter int LOCK_CYC       = pmac_pkg::LOCK_CYC,
  parameter int WDOG_CYC       = pmac_pkg::WDOG_CYC,
  parameter int RSO_CYC        = pmac_pkg::RSO_CYC,
  parameter int CNT_W          = 30
) (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              ce,
  input  wire logic              cfg_wr,
  input  wire logic [47:0]       cfg_wr_data,
  input  wire logic              receive_transmit_select,
  input  wire logic              reg_data_select,
  input  wire logic              watchdog_kick_input,
  input  wire logic              osc_stable,
  input  wire logic              carrier_detect,
  input  wire logic              band_signal,
  input  wire logic              over_temp,
  input  wire logic              level_loop_tick,
  input  wire logic              level_loop_stable,
  output logic [47:0]            cfg_rd_data,
  output pmac_pkg::pmac_ext_t    ext_ctl,
  output logic                   band_busy_heat_flag,
  output logic                   power_line_driver,
  output logic                   tx_enable,
  output logic                   timeout_lock,
  output logic                   level_freeze,
  output logic                   system_reset_output,
  output logic                   internal_reset,
  output logic                   mclk
);

  // ---------------- reset output and watchdog ----------------
  logic             rso_active;
  logic             wd_cause;
  logic [CNT_W-1:0] rso_cnt;
  logic [CNT_W-1:0] wd_cnt;
  logic             kick_prev;
  logic             next_rso_active;
  logic             next_wd_cause;
  logic [CNT_W-1:0] next_rso_cnt;
  logic [CNT_W-1:0] next_wd_cnt;

  always_comb begin
    next_rso_active = rso_active;
    next_wd_cause   = wd_cause;
    next_rso_cnt    = rso_cnt;
    next_wd_cnt     = wd_cnt;
    if (rso_active) begin
      next_wd_cnt = '0;
      // delay only starts once the oscillator has settled
      if (osc_stable) begin
        if (rso_cnt == CNT_W'(RSO_CYC - 1)) begin
          next_rso_active = 1'b0;
          next_wd_cause   = 1'b0;
          next_rso_cnt    = '0;
        end else begin
          next_rso_cnt = CNT_W'(rso_cnt + 1'b1);
        end
      end
    end else if (kick_prev && !watchdog_kick_input) begin
      next_wd_cnt = '0;
    end else if (wd_cnt == CNT_W'(WDOG_CYC - 1)) begin
      next_wd_cnt     = '0;
      next_rso_active = 1'b1;
      next_wd_cause   = 1'b1;
    end else begin
      next_wd_cnt = CNT_W'(wd_cnt + 1'b1);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rso_active          <= 1'b1;
      wd_cause            <= 1'b0;
      rso_cnt             <= '0;
      wd_cnt              <= '0;
      kick_prev           <= 1'b1;
      system_reset_output <= 1'b0;
      internal_reset      <= 1'b0;
    end else if (ce) begin
      rso_active          <= next_rso_active;
      wd_cause            <= next_wd_cause;
      rso_cnt             <= next_rso_cnt;
      wd_cnt              <= next_wd_cnt;
      kick_prev           <= watchdog_kick_input;
      system_reset_output <= ~next_rso_active;
      internal_reset      <= next_wd_cause;
    end
  end

  // watchdog expiry also restores the rest of the block
  logic soft_rst;
  assign soft_rst = wd_cause;

  // ---------------- configuration register ----------------
  logic [47:0] cfg;
  logic [47:0] next_cfg;

  always_comb begin
    next_cfg = cfg;
    if (soft_rst) begin
      next_cfg = pmac_pkg::CFG_RESET;
    end else if (cfg_wr) begin
      next_cfg[pmac_pkg::CFG_LOW_W-1:0] = cfg_wr_data[pmac_pkg::CFG_LOW_W-1:0];
      // upper half only takes data when the same write keeps extension on
      if (cfg_wr_data[pmac_pkg::EXT_BIT]) begin
        next_cfg[47:pmac_pkg::CFG_LOW_W] = cfg_wr_data[47:pmac_pkg::CFG_LOW_W];
      end
    end
  end

  logic ext_on;
  assign ext_on = next_cfg[pmac_pkg::EXT_BIT];

  pmac_pkg::pmac_ext_t next_ext;

  always_comb begin
    next_ext.header_recog_en  = ext_on & next_cfg[pmac_pkg::HDR_REC_BIT];
    next_ext.frame_count_en   = ext_on & next_cfg[pmac_pkg::HDR_REC_BIT]
                                & next_cfg[pmac_pkg::FRM_CNT_BIT];
    next_ext.header_16bit     = ext_on & next_cfg[pmac_pkg::HDR_LEN_BIT];
    next_ext.sensitivity_high = next_cfg[pmac_pkg::SENS_BIT];
    next_ext.input_filter_en  = next_cfg[pmac_pkg::FILT_BIT];
    next_ext.header_pattern   = next_cfg[pmac_pkg::HDR_LSB +: 16];
    next_ext.frame_length     = next_cfg[pmac_pkg::LEN_LSB +: 8];
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg         <= pmac_pkg::CFG_RESET;
      cfg_rd_data <= pmac_pkg::CFG_RESET;
      ext_ctl     <= '0;
    end else if (ce) begin
      cfg         <= next_cfg;
      cfg_rd_data <= next_cfg;
      ext_ctl     <= next_ext;
    end
  end

  // ---------------- transmit time-out guard ----------------
  pmac_pkg::pmac_tx_state_t state;
  pmac_pkg::pmac_tx_state_t next_state;
  logic [CNT_W-1:0]         tcnt;
  logic [CNT_W-1:0]         next_tcnt;
  logic                     strap_done;
  logic                     tx_req;
  logic                     tout_on;
  logic [CNT_W-1:0]         tout_lim;
  logic [1:0]               tout_sel;

  assign tx_req   = ~receive_transmit_select & ~reg_data_select;
  assign tout_sel = cfg[pmac_pkg::TOUT_LSB +: 2];

  always_comb begin
    tout_on  = (tout_sel == pmac_pkg::TOUT_SHORT) || (tout_sel == pmac_pkg::TOUT_LONG);
    tout_lim = (tout_sel == pmac_pkg::TOUT_LONG) ? CNT_W'(TOUT_LONG_CYC - 1)
                                                 : CNT_W'(TOUT_SHORT_CYC - 1);
    next_state = state;
    next_tcnt  = tcnt;
    if (soft_rst) begin
      next_state = pmac_pkg::PMAC_RX;
      next_tcnt  = '0;
    end else if (!strap_done) begin
      // strap sampled on the first enabled edge after reset release
      next_state = tx_req ? pmac_pkg::PMAC_WAIT : pmac_pkg::PMAC_RX;
    end else begin
      unique case (state)
        pmac_pkg::PMAC_RX: begin
          next_tcnt = '0;
          if (tx_req) begin
            next_state = pmac_pkg::PMAC_TX;
          end
        end
        pmac_pkg::PMAC_TX: begin
          if (!tx_req) begin
            next_state = pmac_pkg::PMAC_RX;
            next_tcnt  = '0;
          end else if (tout_on && tcnt == tout_lim) begin
            next_state = pmac_pkg::PMAC_LOCK;
            next_tcnt  = '0;
          end else begin
            next_tcnt = CNT_W'(tcnt + 1'b1);
          end
        end
        pmac_pkg::PMAC_LOCK: begin
          if (tcnt == CNT_W'(LOCK_CYC - 1)) begin
            next_state = pmac_pkg::PMAC_WAIT;
            next_tcnt  = '0;
          end else begin
            next_tcnt = CNT_W'(tcnt + 1'b1);
          end
        end
        pmac_pkg::PMAC_WAIT: begin
          next_tcnt = '0;
          if (receive_transmit_select) begin
            next_state = pmac_pkg::PMAC_RX;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state      <= pmac_pkg::PMAC_RX;
      tcnt       <= '0;
      strap_done <= 1'b0;
    end else if (ce) begin
      state      <= next_state;
      tcnt       <= next_tcnt;
      strap_done <= 1'b1;
    end
  end

  // ---------------- driver, flags and level freeze ----------------
  logic       tx_now;
  logic [1:0] stable_cnt;
  logic [1:0] next_stable_cnt;
  logic       next_freeze;
  logic       freeze_on;

  // transmit only in the active state: lockout and wait both refuse it
  assign tx_now    = (next_state == pmac_pkg::PMAC_TX);
  assign freeze_on = next_cfg[pmac_pkg::EXT_BIT] & ~next_cfg[pmac_pkg::FREEZE_BIT];

  always_comb begin
    next_stable_cnt = stable_cnt;
    next_freeze     = level_freeze;
    if (!tx_now || !freeze_on) begin
      next_stable_cnt = 2'h0;
      next_freeze     = 1'b0;
    end else if (!level_freeze && level_loop_tick) begin
      if (!level_loop_stable) begin
        next_stable_cnt = 2'h0;
      end else if (stable_cnt == 2'(pmac_pkg::FREEZE_PERIODS - 1)) begin
        next_freeze = 1'b1;
      end else begin
        next_stable_cnt = 2'(stable_cnt + 2'h1);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stable_cnt          <= 2'h0;
      level_freeze        <= 1'b0;
      band_busy_heat_flag <= 1'b0;
      power_line_driver   <= 1'b0;
      tx_enable           <= 1'b0;
      timeout_lock        <= 1'b0;
    end else if (ce) begin
      stable_cnt          <= next_stable_cnt;
      level_freeze        <= next_freeze;
      band_busy_heat_flag <= tx_now ? over_temp
                                    : (band_signal & carrier_detect);
      power_line_driver   <= tx_now & ~over_temp;
      tx_enable           <= tx_now;
      timeout_lock        <= (next_state == pmac_pkg::PMAC_LOCK)
                             || (next_state == pmac_pkg::PMAC_WAIT);
    end
  end

  // ---------------- master clock output ----------------
  pmac_clkdiv u_clkdiv (
    .clk      (clk),
    .rst_b    (rst_b),
    .ce       (ce),
    .soft_rst (soft_rst),
    .sel      (cfg[pmac_pkg::MCLK_LSB +: 2]),
    .mclk     (mclk)
  );

endmodule

// File: sim/pmac_host.sv
// host controller model: select lines and watchdog kicks
`timescale 1ns/10ps
module pmac_host (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic tx_req,
  input  wire logic kick_en,
  input  wire logic timeout_lock,
  output logic      receive_transmit_select,
  output logic      reg_data_select,
  output logic      watchdog_kick_input
);
  logic [5:0] kick_cnt;
  // a locked device is sent back to receive before any new request
  assign receive_transmit_select = ~tx_req | timeout_lock;
  assign reg_data_select         = 1'h0;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      kick_cnt            <= 6'h00;
      watchdog_kick_input <= 1'h1;
    end else begin
      kick_cnt            <= kick_cnt + 6'h01;
      // one falling edge per 64 cycles, well inside the watchdog span
      watchdog_kick_input <= ~kick_en | kick_cnt[5];
    end
  end
endmodule

// File: sim/pmac_sva.sv
// property checker for the modem auxiliary control block
`timescale 1ns/10ps
module pmac_sva #(
  parameter int LOCK_CYC = 20
) (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        cfg_wr,
  input wire logic [47:0] cfg_wr_data,
  input wire logic        osc_stable,
  input wire logic        band_signal,
  input wire logic        carrier_detect,
  input wire logic        over_temp,
  input wire logic        level_loop_tick,
  input wire logic        level_loop_stable,
  input wire logic [47:0] cfg_rd_data,
  input wire logic        band_busy_heat_flag,
  input wire logic        power_line_driver,
  input wire logic        tx_enable,
  input wire logic        timeout_lock,
  input wire logic        level_freeze,
  input wire logic        system_reset_output,
  input wire logic        internal_reset
);
  int   lock_run;
  logic lock_tx;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // strap lockout has no minimum span, so only a lock entered from transmit is timed
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lock_run <= 0;
      lock_tx  <= 1'h0;
    end else begin
      lock_run <= timeout_lock ? lock_run + 1 : 0;
      if (!timeout_lock) lock_tx <= tx_enable;
    end
  end
  AST_BAND_RX: assert property (!tx_enable && !$past(tx_enable) && !internal_reset
    |-> band_busy_heat_flag == $past(band_signal && carrier_detect)) else $error("band flag");
  AST_HEAT_TX: assert property (tx_enable && $past(tx_enable)
    |-> band_busy_heat_flag == $past(over_temp) && power_line_driver == !$past(over_temp))
    else $error("heat flag or driver");
  AST_LOCK_MIN: assert property ($fell(timeout_lock) && lock_tx
    |-> $past(lock_run) >= LOCK_CYC - 1) else $error("lockout too short");
  AST_LOCK_NO_TX: assert property (timeout_lock |-> !tx_enable && !power_line_driver)
    else $error("transmit during lockout");
  AST_RSO_STARTUP: assert property (!system_reset_output && !osc_stable
    |=> !system_reset_output) else $error("reset out released early");
  AST_WDOG_RSO: assert property ($fell(system_reset_output)
    |-> internal_reset ##1 (!system_reset_output)[*8]) else $error("watchdog reset");
  AST_EXT_GATE: assert property (cfg_wr && !cfg_wr_data[21] && system_reset_output
    |=> cfg_rd_data[47:24] == $past(cfg_rd_data[47:24])) else $error("upper bits written");
  AST_FREEZE_SET: assert property ($rose(level_freeze) |-> $past(tx_enable
    && level_loop_tick && level_loop_stable && cfg_rd_data[21] && !cfg_rd_data[17]))
    else $error("freeze without cause");
  AST_FREEZE_CLR: assert property (!tx_enable && !$past(tx_enable) |-> !level_freeze)
    else $error("freeze outside transmit");
  COV_LOCK: cover property ($fell(timeout_lock) && lock_tx);
  COV_FREEZE: cover property ($rose(level_freeze));
  COV_WDOG: cover property ($fell(system_reset_output));
endmodule

// File: sim/tb.sv
// self-checking bench of the modem auxiliary control block
`timescale 1ns/10ps
module tb;
  localparam int TS = 40, TL = 120, LK = 20, WD = 300, RS = 10;
  logic clk = 1'h0, rst_b = 1'h0, cfg_wr = 1'h0, osc_stable = 1'h0, tx_req = 1'h1;
  logic carrier_detect = 1'h0, band_signal = 1'h0, over_temp = 1'h0, kick_en = 1'h1;
  logic level_loop_tick = 1'h0, level_loop_stable = 1'h0;
  logic [47:0] cfg_wr_data = 48'h0, cfg_rd_data, d;
  logic band_busy_heat_flag, power_line_driver, tx_enable, timeout_lock, level_freeze, mclk;
  logic system_reset_output, internal_reset, receive_transmit_select, reg_data_select;
  logic watchdog_kick_input;
  pmac_pkg::pmac_ext_t ext_ctl;
  int error_cnt = 0, samples_checked = 0, n, m, lim;
  always #2.5 clk = ~clk;
  pmac_top #(.TOUT_SHORT_CYC(TS), .TOUT_LONG_CYC(TL), .LOCK_CYC(LK), .WDOG_CYC(WD),
             .RSO_CYC(RS)) dut_u (
    .clk, .rst_b, .ce(1'h1), .cfg_wr, .cfg_wr_data, .receive_transmit_select,
    .reg_data_select, .watchdog_kick_input, .osc_stable, .carrier_detect, .band_signal,
    .over_temp, .level_loop_tick, .level_loop_stable, .cfg_rd_data, .ext_ctl,
    .band_busy_heat_flag, .power_line_driver, .tx_enable, .timeout_lock, .level_freeze,
    .system_reset_output, .internal_reset, .mclk);
  pmac_host host_u (.clk, .rst_b, .tx_req, .kick_en, .timeout_lock,
    .receive_transmit_select, .reg_data_select, .watchdog_kick_input);
  task automatic chk(input logic [47:0] g, input logic [47:0] e);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic upto(ref logic s, input logic v, output int c);
    c = 0;
    while (s !== v && c < 2000) begin
      @(negedge clk);
      c++;
    end
    if (c >= 2000) chk(1'h0, 1'h1);
  endtask
  task automatic wr(input logic [47:0] v);
    @(posedge clk);
    cfg_wr <= 1'h1;
    cfg_wr_data <= v;
    @(posedge clk);
    cfg_wr <= 1'h0;
    @(negedge clk);
  endtask
  task automatic tick();
    @(posedge clk);
    level_loop_tick <= 1'h1;
    @(posedge clk);
    level_loop_tick <= 1'h0;
    @(negedge clk);
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #60000;
    chk(1'h0, 1'h1);
    print_verdict();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'h1;
    upto(timeout_lock, 1'h1, n);
    chk(n < 4, 1'h1);
    chk(tx_enable, 1'h0);
    @(posedge clk) tx_req <= 1'h0;
    repeat (20) @(negedge clk);
    chk(system_reset_output, 1'h0);
    @(posedge clk) osc_stable <= 1'h1;
    upto(system_reset_output, 1'h1, n);
    chk(n >= RS - 1 && n <= RS + 1, 1'h1);
    chk(cfg_rd_data, pmac_pkg::CFG_RESET);
    chk(cfg_rd_data[20], 1'h1);
    chk(ext_ctl.header_16bit, 1'h0);
    chk(ext_ctl.header_pattern, 16'h9B58);
    chk(ext_ctl.frame_length, 8'h08);
    wr({24'hFFFFFF, pmac_pkg::CFG_RESET[23:0]});
    chk(cfg_rd_data[47:24], pmac_pkg::CFG_RESET[47:24]);
    for (int b = 0; b < 2; b++) begin
      d = {8'hFF, 16'h1234, 24'h220080 | (24'(b) << 20)};
      wr(d);
      chk(cfg_rd_data, d);
      chk(ext_ctl.header_16bit, b[0]);
      chk({ext_ctl.header_pattern, ext_ctl.frame_length}, 24'h1234FF);
    end
    wr({8'hFF, 16'h1234, 24'hAE0080});
    chk({ext_ctl.header_recog_en, ext_ctl.frame_count_en, ext_ctl.input_filter_en}, 3'h7);
    wr({8'hFF, 16'h1234, 24'h8C0080});
    chk({ext_ctl.header_recog_en, ext_ctl.frame_count_en, ext_ctl.input_filter_en}, 3'h1);
    for (int k = 1; k < 3; k++) begin
      lim = k == 1 ? TS : TL;
      d = {8'h08, 16'h9B58, 24'h220000 | (24'(k) << 7)};
      wr(d);
      @(posedge clk) tx_req <= 1'h1;
      // a short burst first: the next burst must still get the full span
      repeat (20) @(posedge clk);
      tx_req <= 1'h0;
      repeat (3) @(posedge clk);
      tx_req <= 1'h1;
      upto(tx_enable, 1'h1, m);
      upto(timeout_lock, 1'h1, n);
      chk(n + 1 >= lim && n <= lim + 2, 1'h1);
      repeat (4) @(negedge clk);
      chk(tx_enable, 1'h0);
      wr(d | 48'h400000);
      chk(ext_ctl.sensitivity_high, 1'h1);
      @(posedge clk) tx_req <= 1'h0;
      upto(timeout_lock, 1'h0, n);
      chk(n + 7 >= LK, 1'h1);
    end
    @(posedge clk) band_signal <= 1'h1;
    repeat (3) @(negedge clk);
    chk(band_busy_heat_flag, 1'h0);
    @(posedge clk) carrier_detect <= 1'h1;
    repeat (2) @(negedge clk);
    chk(band_busy_heat_flag, 1'h1);
    @(posedge clk) tx_req <= 1'h1;
    repeat (3) @(negedge clk);
    chk({band_busy_heat_flag, power_line_driver}, 2'h1);
    @(posedge clk) over_temp <= 1'h1;
    repeat (2) @(negedge clk);
    chk({band_busy_heat_flag, power_line_driver}, 2'h2);
    @(posedge clk) over_temp <= 1'h0;
    repeat (2) @(negedge clk);
    chk({band_busy_heat_flag, power_line_driver}, 2'h1);
    @(posedge clk) {tx_req, band_signal} <= 2'h0;
    for (int e = 0; e < 2; e++) begin
      wr({8'h08, 16'h9B58, 24'(e) << 21});
      @(posedge clk) {tx_req, level_loop_stable} <= 2'h3;
      tick();
      tick();
      chk(level_freeze, 1'h0);
      tick();
      chk(level_freeze, e[0]);
      @(posedge clk) tx_req <= 1'h0;
      repeat (3) @(negedge clk);
      chk(level_freeze, 1'h0);
    end
    for (int s = 0; s < 4; s++) begin
      wr({8'h08, 16'h9B58, 24'h200000 | (24'(s) << 15)});
      repeat (12) @(negedge clk);
      n = 0;
      m = mclk;
      repeat (48) begin
        @(negedge clk);
        n += (mclk && !m);
        m = mclk;
      end
      chk(n, s == 3 ? 0 : 48 >> (s + 1));
    end
    @(posedge clk) kick_en <= 1'h0;
    upto(system_reset_output, 1'h0, n);
    chk(n > WD - 80 && n <= WD + 2, 1'h1);
    chk(internal_reset, 1'h1);
    @(negedge clk);
    chk(cfg_rd_data, pmac_pkg::CFG_RESET);
    upto(system_reset_output, 1'h1, n);
    chk(n >= RS - 2 && n <= RS + 1, 1'h1);
    @(posedge clk) kick_en <= 1'h1;
    repeat (700) @(negedge clk);
    chk(system_reset_output, 1'h1);
    print_verdict();
  end
endmodule
bind pmac_top pmac_sva #(.LOCK_CYC(LOCK_CYC)) chk_u (.clk, .rst_b, .cfg_wr, .cfg_wr_data,
  .osc_stable, .band_signal, .carrier_detect, .over_temp, .level_loop_tick,
  .level_loop_stable, .cfg_rd_data, .band_busy_heat_flag, .power_line_driver, .tx_enable,
  .timeout_lock, .level_freeze, .system_reset_output, .internal_reset);
